// ===== rtl/lsr_pkg.sv
// Package for the link status and test register bank.
// Assumes one 250 MHz clock and a word-wide register port with byte offsets.
package lsr_pkg;

  // Register offsets on the register port.
  localparam logic [7:0] OFS_RUN_STATE = 8'h00;
  localparam logic [7:0] OFS_SLOW_BUS_RESULT = 8'h04;
  localparam logic [7:0] OFS_ARRAY_FLAG = 8'h08;
  localparam logic [7:0] OFS_RX_RESET = 8'h0c;
  localparam logic [7:0] OFS_CHANNEL_STATE = 8'h10;
  localparam logic [7:0] OFS_LANE_STATE = 8'h14;
  localparam logic [3:0][7:0] OFS_SOFT_CNT = {8'h24, 8'h20, 8'h1c, 8'h18};
  localparam logic [7:0] OFS_CNT_CLEAR = 8'h28;
  // Order: channel 0 data, channel 0 clock, channel 1 data, channel 1 clock.
  localparam logic [3:0][7:0] OFS_TUNE = {8'h38, 8'h34, 8'h30, 8'h2c};

  // Field positions.
  localparam int BIT_RUNNING = 0;
  localparam int BIT_CHECKSUM_OK = 0;
  localparam int BIT_BAD_PACKET = 1;
  localparam int BIT_PARITY_FAULT = 2;
  localparam int CHECKSUM_LSB = 8;
  localparam int BIT_UNSUPPORTED = 0;
  localparam int BIT_RX_RESET = 0;
  localparam int CH_UP_LSB = 0;
  localparam int BIT_CLK_UNLOCKED = 4;
  localparam int BIT_PLL_LOCKED = 5;
  localparam int LANE_UP_LSB = 0;
  localparam int BIT_CNT_CLEAR = 0;
  localparam int SWING_LSB = 0;
  localparam int POST_LSB = 8;
  localparam int PRE_LSB = 16;

  // Widths and counts.
  localparam int NUM_CH = 4;
  localparam int LANES_PER_CH = 3;
  localparam int NUM_LANES = 12;
  localparam int CNT_W = 20;
  localparam int NUM_TUNE = 4;

  // Reset values and constants.
  localparam logic [3:0] SWING_RESET = 4'h9;
  localparam logic [4:0] POST_RESET = 5'h00;
  localparam logic [4:0] PRE_RESET = 5'h00;
  localparam logic [19:0] CNT_MAX = 20'hfffff;
  localparam logic [23:0] CHECKSUM_PASS = 24'h3c7a55;

endpackage : lsr_pkg

// ===== rtl/lsr_regs.sv
// Link status, test result and transmit driver tuning register bank.
// Assumes a simple synchronous register port (one-cycle read or write strobes)
// and status inputs that are already synchronous to clk.

`timescale 1ns/1ps
`default_nettype none

module lsr_regs (
  input wire logic clk,
  input wire logic resetn,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Test engine status.
  input wire logic pattern_test_running,
  input wire logic slow_bus_checksum_ok,
  input wire logic slow_bus_bad_packet,
  input wire logic slow_bus_parity_fault,
  input wire logic [23:0] slow_bus_checksum_value,
  input wire logic unsupported_array_seen,
  // Receive link status.
  input wire logic [3:0] channel_up,
  input wire logic user_clock_unlocked,
  input wire logic first_transceiver_pll_locked,
  input wire logic [11:0] lane_up,
  input wire logic [3:0] soft_error_event,
  output logic receive_link_reset,
  // Transmit driver tuning, index 0..3 as ch0 data, ch0 clock, ch1 data, ch1 clock.
  output logic [3:0][3:0] driver_swing,
  output logic [3:0][4:0] post_cursor_emphasis,
  output logic [3:0][4:0] pre_cursor_emphasis
);

  // Captured status, one cycle behind the inputs.
  logic run_r;
  logic chk_ok_r;
  logic bad_pkt_r;
  logic parity_r;
  logic [23:0] checksum_r;
  logic unsupported_r;
  logic [3:0] ch_up_r;
  logic clk_unlocked_r;
  logic pll_locked_r;
  logic [11:0] lane_up_r;
  logic [19:0] soft_cnt_r [4];
  logic cnt_clear;
  logic [31:0] rdata_nxt;

  // Status is registered so that a read returns a stable snapshot and the
  // read mux never sees an input that changes mid-cycle.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      run_r <= 1'b0;
      chk_ok_r <= 1'b0;
      bad_pkt_r <= 1'b0;
      parity_r <= 1'b0;
      checksum_r <= 24'h000000;
      unsupported_r <= 1'b0;
    end else begin
      run_r <= pattern_test_running;
      chk_ok_r <= slow_bus_checksum_ok;
      bad_pkt_r <= slow_bus_bad_packet;
      parity_r <= slow_bus_parity_fault;
      checksum_r <= slow_bus_checksum_value;
      unsupported_r <= unsupported_array_seen;
    end
  end

  // Receive link status snapshot.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ch_up_r <= 4'h0;
      clk_unlocked_r <= 1'b0;
      pll_locked_r <= 1'b0;
      lane_up_r <= 12'h000;
    end else begin
      ch_up_r <= channel_up;
      clk_unlocked_r <= user_clock_unlocked;
      pll_locked_r <= first_transceiver_pll_locked;
      lane_up_r <= lane_up;
    end
  end

  // Receive reset is a one-cycle pulse; nothing is stored, so it reads as zero.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      receive_link_reset <= 1'b0;
    end else begin
      receive_link_reset <= reg_wr && (reg_addr == lsr_pkg::OFS_RX_RESET)
                            && reg_wdata[lsr_pkg::BIT_RX_RESET];
    end
  end

  // The clear strobe acts in the cycle of the write and leaves no state behind.
  assign cnt_clear = reg_wr && (reg_addr == lsr_pkg::OFS_CNT_CLEAR)
                     && reg_wdata[lsr_pkg::BIT_CNT_CLEAR];

  // One saturating counter per channel. An error in the clear cycle counts
  // as the first error after the clear so that it is not lost.
  generate
    for (genvar c = 0; c < lsr_pkg::NUM_CH; c++) begin : g_cnt
      always_ff @(posedge clk) begin
        if (!resetn) begin
          soft_cnt_r[c] <= 20'h00000;
        end else if (cnt_clear) begin
          soft_cnt_r[c] <= {19'h00000, soft_error_event[c]};
        end else if (soft_error_event[c] && (soft_cnt_r[c] != lsr_pkg::CNT_MAX)) begin
          soft_cnt_r[c] <= soft_cnt_r[c] + 20'h00001;
        end
      end
    end
  endgenerate

  // Tuning registers, one per driver output; clock outputs are separate.
  generate
    for (genvar t = 0; t < lsr_pkg::NUM_TUNE; t++) begin : g_tune
      always_ff @(posedge clk) begin
        if (!resetn) begin
          driver_swing[t] <= lsr_pkg::SWING_RESET;
          post_cursor_emphasis[t] <= lsr_pkg::POST_RESET;
          pre_cursor_emphasis[t] <= lsr_pkg::PRE_RESET;
        end else if (reg_wr && (reg_addr == lsr_pkg::OFS_TUNE[t])) begin
          driver_swing[t] <= reg_wdata[lsr_pkg::SWING_LSB +: 4];
          post_cursor_emphasis[t] <= reg_wdata[lsr_pkg::POST_LSB +: 5];
          pre_cursor_emphasis[t] <= reg_wdata[lsr_pkg::PRE_LSB +: 5];
        end
      end
    end
  endgenerate

  // Read decode. Write-only and unmapped offsets read as zero, as do unused bits.
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_addr == lsr_pkg::OFS_RUN_STATE) begin
      rdata_nxt[lsr_pkg::BIT_RUNNING] = run_r;
    end else if (reg_addr == lsr_pkg::OFS_SLOW_BUS_RESULT) begin
      rdata_nxt[lsr_pkg::BIT_CHECKSUM_OK] = chk_ok_r;
      rdata_nxt[lsr_pkg::BIT_BAD_PACKET] = bad_pkt_r;
      rdata_nxt[lsr_pkg::BIT_PARITY_FAULT] = parity_r;
      rdata_nxt[lsr_pkg::CHECKSUM_LSB +: 24] = checksum_r;
    end else if (reg_addr == lsr_pkg::OFS_ARRAY_FLAG) begin
      rdata_nxt[lsr_pkg::BIT_UNSUPPORTED] = unsupported_r;
    end else if (reg_addr == lsr_pkg::OFS_CHANNEL_STATE) begin
      rdata_nxt[lsr_pkg::CH_UP_LSB +: 4] = ch_up_r;
      rdata_nxt[lsr_pkg::BIT_CLK_UNLOCKED] = clk_unlocked_r;
      rdata_nxt[lsr_pkg::BIT_PLL_LOCKED] = pll_locked_r;
    end else if (reg_addr == lsr_pkg::OFS_LANE_STATE) begin
      rdata_nxt[lsr_pkg::LANE_UP_LSB +: 12] = lane_up_r;
    end else if (reg_addr == lsr_pkg::OFS_SOFT_CNT[0]) begin
      rdata_nxt[19:0] = soft_cnt_r[0];
    end else if (reg_addr == lsr_pkg::OFS_SOFT_CNT[1]) begin
      rdata_nxt[19:0] = soft_cnt_r[1];
    end else if (reg_addr == lsr_pkg::OFS_SOFT_CNT[2]) begin
      rdata_nxt[19:0] = soft_cnt_r[2];
    end else if (reg_addr == lsr_pkg::OFS_SOFT_CNT[3]) begin
      rdata_nxt[19:0] = soft_cnt_r[3];
    end else if (reg_addr == lsr_pkg::OFS_TUNE[0]) begin
      rdata_nxt = {11'h000, pre_cursor_emphasis[0], 3'h0, post_cursor_emphasis[0], 4'h0, driver_swing[0]};
    end else if (reg_addr == lsr_pkg::OFS_TUNE[1]) begin
      rdata_nxt = {11'h000, pre_cursor_emphasis[1], 3'h0, post_cursor_emphasis[1], 4'h0, driver_swing[1]};
    end else if (reg_addr == lsr_pkg::OFS_TUNE[2]) begin
      rdata_nxt = {11'h000, pre_cursor_emphasis[2], 3'h0, post_cursor_emphasis[2], 4'h0, driver_swing[2]};
    end else if (reg_addr == lsr_pkg::OFS_TUNE[3]) begin
      rdata_nxt = {11'h000, pre_cursor_emphasis[3], 3'h0, post_cursor_emphasis[3], 4'h0, driver_swing[3]};
    end
  end

  // Read answer one cycle after the strobe; data holds until the next read.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_read_at(logic [7:0] ofs);
    reg_rd && (reg_addr == ofs);
  endsequence

  sequence s_clear_write;
    reg_wr && (reg_addr == lsr_pkg::OFS_CNT_CLEAR) && reg_wdata[lsr_pkg::BIT_CNT_CLEAR];
  endsequence

  AST_RUN_FLAG_READ: assert property (
    pattern_test_running ##1 s_read_at(lsr_pkg::OFS_RUN_STATE) |=> reg_rvalid && reg_rdata[0])
    else $error("run flag read back as zero while the test ran");

  AST_RESULT_READ: assert property (
    s_read_at(lsr_pkg::OFS_SLOW_BUS_RESULT) |=> reg_rdata[0] == $past(chk_ok_r)
      && reg_rdata[1] == $past(bad_pkt_r) && reg_rdata[2] == $past(parity_r) && reg_rdata[7:3] == 5'h00)
    else $error("slow bus result flags read back wrong");

  AST_CHECKSUM_READ: assert property (
    s_read_at(lsr_pkg::OFS_SLOW_BUS_RESULT) |=> reg_rdata[31:8] == $past(checksum_r))
    else $error("checksum field read back wrong");

  AST_ARRAY_FLAG: assert property (
    unsupported_array_seen ##1 s_read_at(lsr_pkg::OFS_ARRAY_FLAG) |=> reg_rdata == 32'h00000001)
    else $error("unsupported array flag not reported");

  AST_RX_RESET_PULSE: assert property (
    reg_wr && (reg_addr == lsr_pkg::OFS_RX_RESET) && reg_wdata[0] |=> receive_link_reset ##1 !receive_link_reset
      || (reg_wr && reg_addr == lsr_pkg::OFS_RX_RESET))
    else $error("receive reset pulse wrong length");

  AST_RX_RESET_READS_ZERO: assert property (
    s_read_at(lsr_pkg::OFS_RX_RESET) or s_read_at(lsr_pkg::OFS_CNT_CLEAR) |=> reg_rdata == 32'h00000000)
    else $error("write-only register read back nonzero");

  AST_CHANNEL_READ: assert property (
    s_read_at(lsr_pkg::OFS_CHANNEL_STATE) |=> reg_rdata[3:0] == $past(ch_up_r)
      && reg_rdata[4] == $past(clk_unlocked_r) && reg_rdata[5] == $past(pll_locked_r) && reg_rdata[31:6] == 26'h0)
    else $error("channel state read back wrong");

  AST_LANE_READ: assert property (
    lane_up == 12'h800 ##1 s_read_at(lsr_pkg::OFS_LANE_STATE) |=> reg_rdata == 32'h00000800)
    else $error("lane bit for channel 3 lane 2 misplaced");

  AST_CLEAR_ZEROES: assert property (
    s_clear_write and !soft_error_event[0] |=> soft_cnt_r[0] == 20'h00000)
    else $error("counter not cleared by clear write");

  AST_COUNT_STEP: assert property (
    !cnt_clear && soft_error_event[1] && soft_cnt_r[1] != lsr_pkg::CNT_MAX
      |=> soft_cnt_r[1] == $past(soft_cnt_r[1]) + 20'h00001)
    else $error("counter did not step on a soft error");

  AST_SATURATE: assert property (
    !cnt_clear |=> soft_cnt_r[2] >= $past(soft_cnt_r[2]))
    else $error("counter fell without a clear, so it wrapped");

  AST_TUNE_WRITE: assert property (
    reg_wr && reg_addr == lsr_pkg::OFS_TUNE[1] ##1 s_read_at(lsr_pkg::OFS_TUNE[1])
      |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 2) && reg_rdata[12:8] == $past(reg_wdata[12:8], 2)
      && reg_rdata[20:16] == $past(reg_wdata[20:16], 2))
    else $error("tuning register did not hold written fields");

  AST_TUNE_SEPARATE: assert property (
    reg_wr && reg_addr == lsr_pkg::OFS_TUNE[0] |=> $stable(driver_swing[1]) && $stable(pre_cursor_emphasis[1]))
    else $error("data tuning write disturbed clock tuning");

  AST_RUN_FLAG_CLEAR: assert property (
    !pattern_test_running ##1 s_read_at(lsr_pkg::OFS_RUN_STATE) |=> reg_rdata == 32'h00000000)
    else $error("run flag read back as one with no test running");

  AST_RESULT_PASS_CODE: assert property (
    slow_bus_checksum_ok && (slow_bus_checksum_value == lsr_pkg::CHECKSUM_PASS)
      ##1 s_read_at(lsr_pkg::OFS_SLOW_BUS_RESULT)
      |=> reg_rdata[0] && (reg_rdata[31:8] == lsr_pkg::CHECKSUM_PASS))
    else $error("passing checksum not reported");

  AST_BAD_PACKET: assert property (
    slow_bus_bad_packet ##1 s_read_at(lsr_pkg::OFS_SLOW_BUS_RESULT) |=> reg_rdata[1])
    else $error("invalid packet flag not reported");

  AST_PARITY_FAULT: assert property (
    slow_bus_parity_fault ##1 s_read_at(lsr_pkg::OFS_SLOW_BUS_RESULT) |=> reg_rdata[2])
    else $error("parity flag not reported");

  AST_ARRAY_FLAG_CLEAR: assert property (
    !unsupported_array_seen ##1 s_read_at(lsr_pkg::OFS_ARRAY_FLAG) |=> reg_rdata == 32'h00000000)
    else $error("unsupported array flag reported for a supported array");

  AST_RX_RESET_IDLE: assert property (
    !(reg_wr && (reg_addr == lsr_pkg::OFS_RX_RESET) && reg_wdata[lsr_pkg::BIT_RX_RESET]) |=> !receive_link_reset)
    else $error("receive reset pulsed without a write of one");

  AST_CHANNEL_UP_BIT: assert property (
    channel_up[3] ##1 s_read_at(lsr_pkg::OFS_CHANNEL_STATE) |=> reg_rdata[3])
    else $error("channel 3 up not reported in bit 3");

  AST_CLOCK_UNLOCKED: assert property (
    user_clock_unlocked ##1 s_read_at(lsr_pkg::OFS_CHANNEL_STATE) |=> reg_rdata[4])
    else $error("user clock unlock not reported");

  AST_PLL_LOCKED: assert property (
    first_transceiver_pll_locked ##1 s_read_at(lsr_pkg::OFS_CHANNEL_STATE) |=> reg_rdata[5])
    else $error("transceiver pll lock not reported");

  AST_LANE_LOW_BIT: assert property (
    lane_up[0] ##1 s_read_at(lsr_pkg::OFS_LANE_STATE) |=> reg_rdata[0])
    else $error("channel 0 lane 0 up not reported in bit 0");

  AST_LANE_UPPER_ZERO: assert property (
    s_read_at(lsr_pkg::OFS_LANE_STATE) |=> reg_rdata[31:12] == 20'h00000)
    else $error("lane state unused bits read nonzero");

  AST_COUNT_HOLD: assert property (
    !cnt_clear && !soft_error_event[0] |=> $stable(soft_cnt_r[0]))
    else $error("counter moved with no soft error");

  AST_COUNT_UPPER_ZERO: assert property (
    s_read_at(lsr_pkg::OFS_SOFT_CNT[2]) |=> reg_rdata[31:20] == 12'h000)
    else $error("counter unused bits read nonzero");

  AST_CLEAR_WITH_EVENT: assert property (
    s_clear_write and soft_error_event[1] |=> soft_cnt_r[1] == 20'h00001)
    else $error("error in the clear cycle was lost");

  AST_TUNE_HOLD: assert property (
    !(reg_wr && (reg_addr == lsr_pkg::OFS_TUNE[2]))
      |=> $stable(driver_swing[2]) && $stable(post_cursor_emphasis[2]) && $stable(pre_cursor_emphasis[2]))
    else $error("tuning changed without a write");

  AST_TUNE_UNUSED_ZERO: assert property (
    s_read_at(lsr_pkg::OFS_TUNE[3]) |=> reg_rdata[31:21] == 11'h000 && reg_rdata[15:13] == 3'h0
      && reg_rdata[7:4] == 4'h0)
    else $error("tuning unused bits read nonzero");

  // Reset checks override the default disable so that they look at reset itself.
  AST_RESET_TUNING: assert property (
    disable iff (1'b0) !resetn |=> driver_swing[0] == lsr_pkg::SWING_RESET
      && post_cursor_emphasis[0] == lsr_pkg::POST_RESET && pre_cursor_emphasis[0] == lsr_pkg::PRE_RESET)
    else $error("tuning fields missed their reset values");

  AST_RESET_COUNTERS: assert property (
    disable iff (1'b0) !resetn |=> soft_cnt_r[3] == 20'h00000 && !receive_link_reset && !reg_rvalid)
    else $error("counters or strobes not cleared by reset");

endmodule : lsr_regs

`default_nettype wire

// ===== test/link_status_test_regs_test.sv
// Self-checking testbench for the link status and test register bank.
// Assumes the strobe register port of the bank, a 250 MHz clock and no partner model.
`timescale 1ns/1ps
`default_nettype none

module link_status_test_regs_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic run = 1'b0, ok = 1'b0, bad = 1'b0, par = 1'b0, uns = 1'b0, unl = 1'b0, pll = 1'b0;
  logic [23:0] sum = 24'h0;
  logic [3:0] chup = 4'h0;
  logic [11:0] lnup = 12'h0;
  logic [3:0] sev = 4'h0;
  logic rx_rst;
  logic [3:0][3:0] swing;
  logic [3:0][4:0] post;
  logic [3:0][4:0] pre;
  int err_total = 0;
  int comparisons = 0;

  // Free-running 4 ns clock.
  always #2 clk = ~clk;

  lsr_regs dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pattern_test_running(run),
    .slow_bus_checksum_ok(ok), .slow_bus_bad_packet(bad), .slow_bus_parity_fault(par),
    .slow_bus_checksum_value(sum), .unsupported_array_seen(uns), .channel_up(chup),
    .user_clock_unlocked(unl), .first_transceiver_pll_locked(pll), .lane_up(lnup),
    .soft_error_event(sev), .receive_link_reset(rx_rst), .driver_swing(swing),
    .post_cursor_emphasis(post), .pre_cursor_emphasis(pre));

  // Compares a word with case inequality, so unknown bits never pass.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One read strobe; valid and data are checked just after the edge that takes the strobe.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, exp);
  endtask : rd

  // One write strobe; returns just after the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Packs the tuning outputs of one register in its read-back layout.
  function automatic logic [31:0] tp(input int k);
    return {11'h0, pre[k], 3'h0, post[k], 4'h0, swing[k]};
  endfunction : tp

  task automatic do_reset;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
  endtask : do_reset

  task automatic t_reset_values;
    for (int k = 0; k < 4; k++) begin
      chk(tp(k), 32'h9);
      rd(lsr_pkg::OFS_TUNE[k], 32'h9);
    end
    rd(lsr_pkg::OFS_RX_RESET, 32'h0);
    rd(lsr_pkg::OFS_CNT_CLEAR, 32'h0);
    rd(lsr_pkg::OFS_SOFT_CNT[3], 32'h0);
    rd(8'hfc, 32'h0);
    $display("test reset_values done");
  endtask : t_reset_values

  // Drives one set of status levels and reads every status register back.
  task automatic t_status(input logic r, o, b, p, u, cu, pl, input logic [23:0] s,
    input logic [3:0] ch, input logic [11:0] ln);
    @(posedge clk);
    // The run length of a lane test is set outside this bank; only the run level is driven.
    run <= r;
    ok <= o;
    bad <= b;
    par <= p;
    uns <= u;
    unl <= cu;
    pll <= pl;
    sum <= s;
    chup <= ch;
    lnup <= ln;
    rd(lsr_pkg::OFS_RUN_STATE, {31'h0, r});
    rd(lsr_pkg::OFS_SLOW_BUS_RESULT, {s, 5'h0, p, b, o});
    rd(lsr_pkg::OFS_ARRAY_FLAG, {31'h0, u});
    rd(lsr_pkg::OFS_CHANNEL_STATE, {26'h0, pl, cu, ch});
    rd(lsr_pkg::OFS_LANE_STATE, {20'h0, ln});
    $display("test status done");
  endtask : t_status

  task automatic t_rx_reset;
    wr(lsr_pkg::OFS_RX_RESET, 32'h1);
    chk({31'h0, rx_rst}, 32'h1);
    @(posedge clk);
    #1;
    chk({31'h0, rx_rst}, 32'h0);
    wr(lsr_pkg::OFS_RX_RESET, 32'h0);
    chk({31'h0, rx_rst}, 32'h0);
    rd(lsr_pkg::OFS_RX_RESET, 32'h0);
    $display("test rx_reset done");
  endtask : t_rx_reset

  // Distinct all-field patterns per register expose crossed decodes; a reset in mid-run follows.
  task automatic t_tuning;
    for (int k = 0; k < 4; k++) wr(lsr_pkg::OFS_TUNE[k], 32'hffffffff - k * 32'h00010102);
    wr(lsr_pkg::OFS_CHANNEL_STATE, 32'hffffffff);
    wr(8'hfc, 32'hffffffff);
    for (int k = 0; k < 4; k++) begin
      chk(tp(k), (32'hffffffff - k * 32'h00010102) & 32'h001f1f0f);
      rd(lsr_pkg::OFS_TUNE[k], (32'hffffffff - k * 32'h00010102) & 32'h001f1f0f);
    end
    rd(lsr_pkg::OFS_CHANNEL_STATE, {26'h0, pll, unl, chup});
    // A read right behind a write must already see the new fields.
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= lsr_pkg::OFS_TUNE[1];
    reg_wdata <= 32'hffeaf5f6;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, 32'h000a1506);
    chk(tp(1), 32'h000a1506);
    do_reset();
    for (int k = 0; k < 4; k++) rd(lsr_pkg::OFS_TUNE[k], 32'h9);
    $display("test tuning done");
  endtask : t_tuning

  // Channel n sees n+1 events; then a clear that coincides with a channel 1 event.
  task automatic t_counters;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      sev <= 4'hf << i;
    end
    @(posedge clk);
    sev <= 4'h0;
    wr(lsr_pkg::OFS_SOFT_CNT[0], 32'hfffff);
    for (int n = 0; n < 4; n++) rd(lsr_pkg::OFS_SOFT_CNT[n], 32'(n + 1));
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= lsr_pkg::OFS_CNT_CLEAR;
    reg_wdata <= 32'h1;
    sev <= 4'h2;
    @(posedge clk);
    reg_wr <= 1'b0;
    sev <= 4'h0;
    for (int n = 0; n < 4; n++) rd(lsr_pkg::OFS_SOFT_CNT[n], (n == 1) ? 32'h1 : 32'h0);
    rd(lsr_pkg::OFS_CNT_CLEAR, 32'h0);
    $display("test counters done");
  endtask : t_counters

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence: reset held for four cycles, then every scenario in turn.
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset_values();
    t_status(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 24'h3c7a55, 4'ha, 12'ha5c);
    t_status(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 24'hc385aa, 4'h5, 12'h5a3);
    t_status(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 24'h000000, 4'h0, 12'h800);
    t_rx_reset();
    t_tuning();
    t_counters();
    report_and_stop();
  end
endmodule : link_status_test_regs_test

`default_nettype wire
